// File: aic_pkg.sv
// Package with command codes, field positions and timing for the axis input counter setup.
`default_nettype none
package aic_pkg;
  localparam logic [7:0]  CMD_WR_ENV2   = 8'h9d;
  localparam logic [7:0]  CMD_RD_ENV2   = 8'hdd;
  localparam logic [7:0]  CMD_WR_ENV3   = 8'h9e;
  localparam logic [7:0]  CMD_RD_ENV3   = 8'hde;
  localparam logic [7:0]  CMD_LATCH     = 8'h29;
  localparam logic [7:0]  CMD_CLR_STOP  = 8'h2d;
  localparam logic [31:0] ENV2_RESET    = 32'h0000_0000;
  localparam logic [31:0] ENV3_RESET    = 32'h0000_0000;
  localparam logic [31:0] ENV3_RW_MASK  = 32'h01ff_ffff;
  // Environment two field positions.
  localparam int E2_ENC_OFF   = 14;
  localparam int E2_PLS_OFF   = 15;
  localparam int E2_ENC_MODE  = 16;
  localparam int E2_ENC_FILT  = 18;
  localparam int E2_ENC_DIR   = 19;
  localparam int E2_PLS_MODE  = 20;
  localparam int E2_PLS_FILT  = 22;
  localparam int E2_PLS_DIR   = 23;
  localparam int E2_Z_COUNT   = 24;
  localparam int E2_Z_EDGE    = 28;
  localparam int E2_ORG_MODE  = 29;
  localparam int E2_STOP_IEN  = 30;
  localparam int E2_CLR_MODE  = 31;
  // Environment three field positions.
  localparam int E3_C1_TGT    = 0;
  localparam int E3_C2_TGT    = 1;
  localparam int E3_C1_INH    = 2;
  localparam int E3_C2_INH    = 3;
  localparam int E3_C1_LCLR   = 4;
  localparam int E3_C1_PINOFF = 5;
  localparam int E3_C1_ORGLAT = 6;
  localparam int E3_C1_RING   = 7;
  localparam int E3_C2_LCLR   = 8;
  // Input modes.
  localparam logic [1:0] MODE_X1 = 2'h0;
  localparam logic [1:0] MODE_X2 = 2'h1;
  localparam logic [1:0] MODE_X4 = 2'h2;
  localparam logic [1:0] MODE_2P = 2'h3;
  // Noise filter least pulse widths and their cycle counts.
  localparam real CLK_FREQ_MHZ   = 200.0;
  localparam real FILT_SHORT_US  = 0.1;
  localparam real FILT_LONG_US   = 0.15;
  localparam int  FILT_W         = 5;
  localparam logic [FILT_W-1:0] FILT_SHORT_CYC =
    FILT_W'(int'($ceil(FILT_SHORT_US * CLK_FREQ_MHZ - 0.001)));
  localparam logic [FILT_W-1:0] FILT_LONG_CYC =
    FILT_W'(int'($ceil(FILT_LONG_US * CLK_FREQ_MHZ - 0.001)));
  typedef struct packed {
    logic up;
    logic dn;
    logic err;
  } aic_count_t;
  typedef enum logic [3:0] {
    ORG_IDLE = 4'b0001,
    ORG_SEEK = 4'b0010,
    ORG_ZCNT = 4'b0100,
    ORG_DONE = 4'b1000
  } aic_org_t;
endpackage : aic_pkg
`default_nettype wire

// File: aic_input_stage.sv
// Noise filter and quadrature or two-pulse decoder used for encoder and pulser inputs.
`default_nettype none
module aic_filter #(
  parameter int W = 5
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         sig_in,
  input  wire logic [W-1:0] min_len,
  output logic              sig_out
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         out_next;

  // A change is passed only after it has held for min_len cycles.
  always_comb
  begin
    cnt_next = '0;
    out_next = sig_out;
    if (sig_in != sig_out)
    begin
      if (cnt_reg == min_len - W'(1))
        out_next = sig_in;
      else
        cnt_next = cnt_reg + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= '0;
      sig_out <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      sig_out <= out_next;
    end
  end
endmodule : aic_filter

module aic_decoder (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               in_a,
  input  wire logic               in_b,
  input  wire logic               disable_in,
  input  wire logic               long_filt,
  input  wire logic               reverse,
  input  wire logic [1:0]         mode,
  output aic_pkg::aic_count_t     cnt
);
  logic                       fa;
  logic                       fb;
  logic                       pa_reg;
  logic                       pb_reg;
  logic [aic_pkg::FILT_W-1:0] flen;
  aic_pkg::aic_count_t        cnt_next;

  assign flen = long_filt ? aic_pkg::FILT_LONG_CYC : aic_pkg::FILT_SHORT_CYC;

  aic_filter #(.W(aic_pkg::FILT_W)) u_fa (
    .clk(clk), .rst_n(rst_n), .sig_in(in_a), .min_len(flen), .sig_out(fa));
  aic_filter #(.W(aic_pkg::FILT_W)) u_fb (
    .clk(clk), .rst_n(rst_n), .sig_in(in_b), .min_len(flen), .sig_out(fb));

  always_comb
  begin
    logic ar;
    logic af;
    logic br;
    logic bf;
    logic up;
    logic dn;
    ar = fa & ~pa_reg;
    af = ~fa & pa_reg;
    br = fb & ~pb_reg;
    bf = ~fb & pb_reg;
    up = 1'b0;
    dn = 1'b0;
    unique case (mode)
      aic_pkg::MODE_X1:
      begin
        up = ar & ~fb;
        dn = af & ~fb;
      end
      aic_pkg::MODE_X2:
      begin
        up = (ar & ~fb) | (af & fb);
        dn = (ar & fb) | (af & ~fb);
      end
      aic_pkg::MODE_X4:
      begin
        up = (ar & ~fb) | (af & fb) | (br & fa) | (bf & ~fa);
        dn = (ar & fb) | (af & ~fb) | (br & ~fa) | (bf & fa);
      end
      aic_pkg::MODE_2P:
      begin
        up = ar;
        dn = br;
      end
    endcase
    // Both phases moving in one cycle cannot come from a clean quadrature source.
    cnt_next.err = (ar | af) & (br | bf) & (mode != aic_pkg::MODE_2P);
    cnt_next.up  = reverse ? dn : up;
    cnt_next.dn  = reverse ? up : dn;
    if (disable_in)
      cnt_next = '0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pa_reg <= 1'b0;
      pb_reg <= 1'b0;
      cnt    <= '0;
    end
    else
    begin
      pa_reg <= fa;
      pb_reg <= fb;
      cnt    <= cnt_next;
    end
  end
endmodule : aic_decoder
`default_nettype wire

// File: aic_axis_setup.sv
// Axis environment registers with encoder, pulser, origin return and counter logic.
`default_nettype none
// How it works
// - Encoder disable bit silences encoder A/B counting and its error flag.
// - Pulser disable bit silences pulser A/B counting and its error flag.
// - Encoder mode field picks x1, x2, x4 or two-pulse counting.
// - Encoder filter bit picks 0.1 or 0.15 us least width on A, B, Z.
// - Encoder direction bit reverses encoder count sense.
// - Pulser mode field picks x1, x2, x4 or two-pulse counting.
// - Pulser filter bit picks 0.1 or 0.15 us least width.
// - Pulser direction bit reverses pulser count sense.
// - Z count field sets how many Z pulses end origin return, zero means first.
// - Z edge bit picks falling or rising Z detection.
// - Origin mode 0: stop at origin, immediately or by deceleration.
// - Origin mode 0 clears the position counter when origin turns on.
// - Origin mode 1 constant speed stops after the set Z pulses.
// - Origin mode 1 high speed decelerates at origin, stops and clears at Z count.
// - Stop interrupt enable sets the stop flag and pulls interrupt low on stop.
// - Clear mode bit: flags clear on read, or only by explicit clear.
// - Serial bus access forces clear by writing.
// - Counter targets select commanded pulses or encoder input.
// - Inhibit bits stop counter 1 and counter 2 counting.
// - Latch-clear bits zero a counter as it is latched.
// - Pin latch off bit blocks pin latch of counter 1, command still latches.
// - Origin latch bit latches counter 1 at origin; ring bit wraps at comparator 1.
module aic_axis_setup #(
  parameter int CNT_W = 28
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             cmd_valid,
  input  wire logic [7:0]       cmd_code,
  input  wire logic [31:0]      cmd_wdata,
  input  wire logic             serial_mode,
  input  wire logic             status_read,
  input  wire logic             enc_a,
  input  wire logic             enc_b,
  input  wire logic             encoder_zphase_input,
  input  wire logic             pls_a,
  input  wire logic             pls_b,
  input  wire logic             cmd_pulse,
  input  wire logic             cmd_dir,
  input  wire logic             origin_on,
  input  wire logic             origin_return_active,
  input  wire logic             high_speed_start,
  input  wire logic             axis_stopped,
  input  wire logic             latch_trigger,
  input  wire logic [CNT_W-1:0] comp1_value,
  output logic [31:0]           rd_data,
  output logic                  rd_valid,
  output logic                  int_n,
  output logic                  stop_interrupt_flag,
  output logic                  enc_err,
  output logic                  pls_err,
  output logic                  pls_up,
  output logic                  pls_dn,
  output logic                  stop_req,
  output logic                  decel_req,
  output logic [CNT_W-1:0]      counter_one,
  output logic [CNT_W-1:0]      counter_two,
  output logic [CNT_W-1:0]      latch_register_one,
  output logic [CNT_W-1:0]      latch_register_two
);
  logic                 rst_s1;
  logic                 rst_n;
  logic [31:0]          env2_reg;
  logic [31:0]          env2_next;
  logic [31:0]          env3_reg;
  logic [31:0]          env3_next;
  logic [31:0]          rd_next;
  logic                 flag_next;
  logic                 zf;
  logic                 zprev_reg;
  logic                 org_prev_reg;
  logic [3:0]           zcnt_reg;
  logic [3:0]           zcnt_next;
  aic_pkg::aic_org_t    state_reg;
  aic_pkg::aic_org_t    state_next;
  logic                 stop_next;
  logic                 decel_next;
  logic                 org_hit;
  logic [CNT_W-1:0]     c1_next;
  logic [CNT_W-1:0]     c2_next;
  logic [CNT_W-1:0]     l1_next;
  logic [CNT_W-1:0]     l2_next;
  logic                 lat1;
  logic                 lat2;
  logic                 clr1;
  logic                 latch_cmd;
  logic                 clear_by_write;
  logic                 flag_set;
  logic                 flag_clr;
  logic                 zedge;
  logic                 org_edge;
  aic_pkg::aic_count_t  enc_cnt;
  aic_pkg::aic_count_t  pls_cnt;

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  aic_decoder u_enc (
    .clk        (ref_clk),
    .rst_n      (rst_n),
    .in_a       (enc_a),
    .in_b       (enc_b),
    .disable_in (env2_reg[aic_pkg::E2_ENC_OFF]),
    .long_filt  (env2_reg[aic_pkg::E2_ENC_FILT]),
    .reverse    (env2_reg[aic_pkg::E2_ENC_DIR]),
    .mode       (env2_reg[aic_pkg::E2_ENC_MODE +: 2]),
    .cnt        (enc_cnt)
  );
  aic_decoder u_pls (
    .clk        (ref_clk),
    .rst_n      (rst_n),
    .in_a       (pls_a),
    .in_b       (pls_b),
    .disable_in (env2_reg[aic_pkg::E2_PLS_OFF]),
    .long_filt  (env2_reg[aic_pkg::E2_PLS_FILT]),
    .reverse    (env2_reg[aic_pkg::E2_PLS_DIR]),
    .mode       (env2_reg[aic_pkg::E2_PLS_MODE +: 2]),
    .cnt        (pls_cnt)
  );
  // The Z input shares the encoder filter setting.
  aic_filter #(.W(aic_pkg::FILT_W)) u_zf (
    .clk     (ref_clk),
    .rst_n   (rst_n),
    .sig_in  (encoder_zphase_input),
    .min_len (env2_reg[aic_pkg::E2_ENC_FILT] ? aic_pkg::FILT_LONG_CYC
                                             : aic_pkg::FILT_SHORT_CYC),
    .sig_out (zf)
  );
  assign zedge     = env2_reg[aic_pkg::E2_Z_EDGE] ? (zf & ~zprev_reg)
                                                  : (~zf & zprev_reg);
  assign org_edge  = origin_on & ~org_prev_reg;
  assign latch_cmd = cmd_valid && (cmd_code == aic_pkg::CMD_LATCH);

  // Register file, read port and stop flag.
  always_comb
  begin
    env2_next = env2_reg;
    env3_next = env3_reg;
    rd_next   = rd_data;
    if (cmd_valid && cmd_code == aic_pkg::CMD_WR_ENV2)
      env2_next = cmd_wdata;
    if (cmd_valid && cmd_code == aic_pkg::CMD_WR_ENV3)
      env3_next = cmd_wdata & aic_pkg::ENV3_RW_MASK;
    if (cmd_valid && cmd_code == aic_pkg::CMD_RD_ENV2)
      rd_next = env2_reg;
    if (cmd_valid && cmd_code == aic_pkg::CMD_RD_ENV3)
      rd_next = env3_reg;
    clear_by_write = env2_reg[aic_pkg::E2_CLR_MODE] | serial_mode;
    flag_set = axis_stopped & env2_reg[aic_pkg::E2_STOP_IEN];
    flag_clr = clear_by_write ? (cmd_valid && cmd_code == aic_pkg::CMD_CLR_STOP)
                              : status_read;
    // A stop in the same cycle as a clear is kept.
    flag_next = flag_set | (stop_interrupt_flag & ~flag_clr);
  end
  // Origin return sequencing.
  always_comb
  begin
    state_next = state_reg;
    zcnt_next  = zcnt_reg;
    stop_next  = 1'b0;
    decel_next = 1'b0;
    org_hit    = 1'b0;
    unique case (state_reg)
      aic_pkg::ORG_IDLE:
        if (origin_return_active)
          state_next = aic_pkg::ORG_SEEK;
      aic_pkg::ORG_SEEK:
        if (!origin_return_active)
          state_next = aic_pkg::ORG_IDLE;
        else if (org_edge && !env2_reg[aic_pkg::E2_ORG_MODE])
        begin
          stop_next  = ~high_speed_start;
          decel_next = high_speed_start;
          org_hit    = 1'b1;
          state_next = aic_pkg::ORG_DONE;
        end
        else if (org_edge)
        begin
          decel_next = high_speed_start;
          zcnt_next  = 4'h0;
          state_next = aic_pkg::ORG_ZCNT;
        end
      aic_pkg::ORG_ZCNT:
        if (!origin_return_active)
          state_next = aic_pkg::ORG_IDLE;
        else if (zedge)
        begin
          if (zcnt_reg == env2_reg[aic_pkg::E2_Z_COUNT +: 4])
          begin
            stop_next  = 1'b1;
            org_hit    = 1'b1;
            state_next = aic_pkg::ORG_DONE;
          end
          else
            zcnt_next = zcnt_reg + 4'h1;
        end
      aic_pkg::ORG_DONE:
        if (!origin_return_active)
          state_next = aic_pkg::ORG_IDLE;
    endcase
  end
  // Counters and latches.
  always_comb
  begin
    logic u1;
    logic d1;
    logic u2;
    logic d2;
    u1 = env3_reg[aic_pkg::E3_C1_TGT] ? enc_cnt.up : (cmd_pulse & ~cmd_dir);
    d1 = env3_reg[aic_pkg::E3_C1_TGT] ? enc_cnt.dn : (cmd_pulse & cmd_dir);
    u2 = env3_reg[aic_pkg::E3_C2_TGT] ? (cmd_pulse & ~cmd_dir) : enc_cnt.up;
    d2 = env3_reg[aic_pkg::E3_C2_TGT] ? (cmd_pulse & cmd_dir) : enc_cnt.dn;
    lat1 = (latch_trigger & ~env3_reg[aic_pkg::E3_C1_PINOFF]) | latch_cmd
           | (org_hit & env3_reg[aic_pkg::E3_C1_ORGLAT]);
    lat2 = latch_trigger | latch_cmd;
    clr1 = org_hit | (lat1 & env3_reg[aic_pkg::E3_C1_LCLR]);
    l1_next = lat1 ? counter_one : latch_register_one;
    l2_next = lat2 ? counter_two : latch_register_two;
    c1_next = counter_one;
    c2_next = counter_two;
    if (clr1)
      c1_next = '0;
    else if (!env3_reg[aic_pkg::E3_C1_INH])
    begin
      if (u1 && !d1)
        c1_next = (env3_reg[aic_pkg::E3_C1_RING] && counter_one == comp1_value)
                  ? '0 : counter_one + CNT_W'(1);
      else if (d1 && !u1)
        c1_next = (env3_reg[aic_pkg::E3_C1_RING] && counter_one == '0)
                  ? comp1_value : counter_one - CNT_W'(1);
    end
    if (lat2 && env3_reg[aic_pkg::E3_C2_LCLR])
      c2_next = '0;
    else if (!env3_reg[aic_pkg::E3_C2_INH])
    begin
      if (u2 && !d2)
        c2_next = counter_two + CNT_W'(1);
      else if (d2 && !u2)
        c2_next = counter_two - CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      env2_reg            <= aic_pkg::ENV2_RESET;
      env3_reg            <= aic_pkg::ENV3_RESET;
      rd_data             <= 32'h0000_0000;
      rd_valid            <= 1'b0;
      stop_interrupt_flag <= 1'b0;
      int_n               <= 1'b1;
      enc_err             <= 1'b0;
      pls_err             <= 1'b0;
      pls_up              <= 1'b0;
      pls_dn              <= 1'b0;
      zprev_reg           <= 1'b0;
      org_prev_reg        <= 1'b0;
      state_reg           <= aic_pkg::ORG_IDLE;
      zcnt_reg            <= 4'h0;
      stop_req            <= 1'b0;
      decel_req           <= 1'b0;
      counter_one         <= '0;
      counter_two         <= '0;
      latch_register_one  <= '0;
      latch_register_two  <= '0;
    end
    else
    begin
      env2_reg            <= env2_next;
      env3_reg            <= env3_next;
      rd_data             <= rd_next;
      rd_valid            <= cmd_valid && (cmd_code == aic_pkg::CMD_RD_ENV2 ||
                                           cmd_code == aic_pkg::CMD_RD_ENV3);
      stop_interrupt_flag <= flag_next;
      int_n               <= ~flag_next;
      enc_err             <= enc_cnt.err;
      pls_err             <= pls_cnt.err;
      pls_up              <= pls_cnt.up;
      pls_dn              <= pls_cnt.dn;
      zprev_reg           <= zf;
      org_prev_reg        <= origin_on;
      state_reg           <= state_next;
      zcnt_reg            <= zcnt_next;
      stop_req            <= stop_next;
      decel_req           <= decel_next;
      counter_one         <= c1_next;
      counter_two         <= c2_next;
      latch_register_one  <= l1_next;
      latch_register_two  <= l2_next;
    end
  end

  a_stop_sets_int: assert property (@(posedge ref_clk) disable iff (!rst_n)
    flag_set |=> (stop_interrupt_flag && !int_n))
    else $error("Stop with interrupt enabled did not raise the flag.");
  a_auto_read_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (status_read && !clear_by_write && !flag_set) |=> !stop_interrupt_flag)
    else $error("Flag did not clear on read in automatic mode.");
  a_serial_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (serial_mode && stop_interrupt_flag && !cmd_valid) |=> stop_interrupt_flag)
    else $error("Flag cleared without a write under serial access.");
  a_enc_off_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(env2_reg[aic_pkg::E2_ENC_OFF]) |-> (enc_cnt == '0))
    else $error("Disabled encoder still produced counts or errors.");
  a_pls_off_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
    env2_reg[aic_pkg::E2_PLS_OFF] ##1 env2_reg[aic_pkg::E2_PLS_OFF] |=> !pls_up && !pls_err)
    else $error("Disabled pulser still produced counts or errors.");
  a_inhibit_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (env3_reg[aic_pkg::E3_C1_INH] && !clr1) |=> $stable(counter_one))
    else $error("Inhibited counter one changed.");
  a_env3_reserved: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cmd_valid && cmd_code == aic_pkg::CMD_RD_ENV3) |=> (rd_data[31:25] == 7'h00 && rd_valid))
    else $error("Reserved bits of environment three read nonzero.");
  a_origin0_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == aic_pkg::ORG_SEEK && origin_return_active && org_edge
     && !env2_reg[aic_pkg::E2_ORG_MODE])
    |=> (counter_one == '0 && state_reg == aic_pkg::ORG_DONE))
    else $error("Origin mode 0 did not clear counter one.");
  a_latch_command: assert property (@(posedge ref_clk) disable iff (!rst_n)
    latch_cmd |=> (latch_register_one == $past(counter_one)))
    else $error("Latch command did not capture counter one.");
endmodule : aic_axis_setup
`default_nettype wire

// File: aic_quad_model.sv
// Quadrature source standing in for the encoder or the manual pulser.
`default_nettype none
module aic_quad_model (
  input  wire logic       ref_clk,
  input  wire logic       go,
  input  wire logic [7:0] steps,
  output logic            qa,
  output logic            qb,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] ph = 2'h0;
  assign qa = ph[0] ^ ph[1];
  assign qb = ph[1];
  initial busy = 1'b0;
  // Edges are 40 cycles apart, so both filter settings pass each one.
  always
  begin
    @(posedge ref_clk iff go);
    #1 busy = 1'b1;
    repeat (steps)
    begin
      repeat (40) @(posedge ref_clk);
      #1 ph = ph + 2'h1;
    end
    repeat (40) @(posedge ref_clk);
    #1 busy = 1'b0;
  end
endmodule : aic_quad_model
`default_nettype wire

// File: tb.sv
// Self-checking bench for the axis input counter setup block.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CW = 28;
  logic ref_clk, rst_b, cmd_valid, serial_mode, status_read, encoder_zphase_input;
  logic cmd_pulse, cmd_dir, origin_on, origin_return_active, high_speed_start;
  logic axis_stopped, latch_trigger, to_pls, go, busy, qa, qb;
  logic [7:0] cmd_code, steps;
  logic [31:0] cmd_wdata, rd_data;
  logic [CW-1:0] comp1_value, counter_one, counter_two, latch_register_one, latch_register_two;
  logic rd_valid, int_n, stop_interrupt_flag, pls_up, pls_dn, stop_req, decel_req, enc_err, pls_err;
  wire logic enc_a = qa & ~to_pls;
  wire logic enc_b = qb & ~to_pls;
  wire logic pls_a = qa & to_pls;
  wire logic pls_b = qb & to_pls;
  int err_total, checked, n_up, n_dn, n_stop, n_dec, n_ee, n_pe;
  aic_axis_setup #(.CNT_W(CW)) dut (.ref_clk, .rst_b, .cmd_valid, .cmd_code, .cmd_wdata,
    .serial_mode, .status_read, .enc_a, .enc_b, .encoder_zphase_input, .pls_a, .pls_b,
    .cmd_pulse, .cmd_dir, .origin_on, .origin_return_active, .high_speed_start, .axis_stopped,
    .latch_trigger, .comp1_value, .rd_data, .rd_valid, .int_n, .stop_interrupt_flag,
    .enc_err, .pls_err, .pls_up, .pls_dn, .stop_req, .decel_req, .counter_one,
    .counter_two, .latch_register_one, .latch_register_two);
  aic_quad_model model (.ref_clk, .go, .steps, .qa, .qb, .busy);
  initial
  begin
    {ref_clk, rst_b, cmd_valid, serial_mode, status_read, encoder_zphase_input} = '0;
    {cmd_pulse, cmd_dir, origin_on, origin_return_active, high_speed_start} = '0;
    {axis_stopped, latch_trigger, to_pls, go, cmd_code, steps, cmd_wdata} = '0;
    comp1_value = CW'(3);
  end
  always #2.5 ref_clk = ~ref_clk;
  // Output pulses last one cycle, so they are tallied at every edge.
  always @(posedge ref_clk)
  begin
    n_up += int'(pls_up === 1'b1);
    n_dn += int'(pls_dn === 1'b1);
    n_stop += int'(stop_req === 1'b1);
    n_dec += int'(decel_req === 1'b1);
    n_ee += int'(enc_err === 1'b1);
    n_pe += int'(pls_err === 1'b1);
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_n
  task automatic pulse(ref logic s);
    wait_n(1);
    s = 1'b1;
    wait_n(1);
    s = 1'b0;
    wait_n(2);
  endtask : pulse
  task automatic cmd(input logic [7:0] code, input logic [31:0] data);
    wait_n(1);
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_wdata = data;
    wait_n(1);
    cmd_valid = 1'b0;
  endtask : cmd
  task automatic rd(input logic [7:0] code, input logic [31:0] exp);
    cmd(code, 32'h0);
    chk("rd_valid", 32'h1, 32'(rd_valid));
    chk("rd_data", exp, rd_data);
  endtask : rd
  task automatic do_reset();
    rst_b = 1'b0;
    wait_n(2);
    rst_b = 1'b1;
    wait_n(4);
  endtask : do_reset
  task automatic run(input logic [7:0] n);
    steps = n;
    pulse(go);
    for (int i = 0; i < 4000 && busy; i++)
      wait_n(1);
    wait_n(5);
  endtask : run
  task automatic t_regs();
    do_reset();
    rd(aic_pkg::CMD_RD_ENV2, aic_pkg::ENV2_RESET);
    cmd(aic_pkg::CMD_WR_ENV3, 32'hffff_ffff);
    rd(aic_pkg::CMD_RD_ENV3, 32'h01ff_ffff);
    cmd(aic_pkg::CMD_WR_ENV2, 32'h5a5a_c000);
    cmd(8'h11, 32'hffff_ffff);
    rd(aic_pkg::CMD_RD_ENV2, 32'h5a5a_c000);
  endtask : t_regs
  task automatic t_encoder();
    logic [CW-1:0] e = '0;
    do_reset();
    cmd(aic_pkg::CMD_WR_ENV3, 32'h1);
    for (int m = 0; m < 3; m++)
    begin
      cmd(aic_pkg::CMD_WR_ENV2, 32'(m) << aic_pkg::E2_ENC_MODE);
      run(8);
      e = e + CW'(8 >> (2 - m));
      chk("counter_one", 32'(e), 32'(counter_one));
      chk("counter_two", 32'(e), 32'(counter_two));
    end
    cmd(aic_pkg::CMD_WR_ENV2, 32'h000a_0000);
    run(8);
    e = e - CW'(8);
    chk("counter_one", 32'(e), 32'(counter_one));
    cmd(aic_pkg::CMD_WR_ENV3, 32'h5);
    run(4);
    chk("counter_one", 32'(e), 32'(counter_one));
    chk("counter_two", 32'(e - CW'(4)), 32'(counter_two));
    cmd(aic_pkg::CMD_WR_ENV2, 32'h000a_4000);
    run(4);
    chk("counter_two", 32'(e - CW'(4)), 32'(counter_two));
  endtask : t_encoder
  task automatic t_pulser();
    do_reset();
    to_pls = 1'b1;
    cmd(aic_pkg::CMD_WR_ENV2, 32'h00a0_0000);
    run(8);
    chk("pls_dn", 32'd8, 32'(n_dn));
    chk("pls_up", 32'd0, 32'(n_up));
    cmd(aic_pkg::CMD_WR_ENV2, 32'h00a0_8000);
    run(4);
    chk("pls_dn", 32'd8, 32'(n_dn));
    cmd(aic_pkg::CMD_WR_ENV2, 32'h0030_0000);
    run(8);
    chk("pls_up", 32'd2, 32'(n_up));
    chk("pls_dn", 32'd10, 32'(n_dn));
    // Both phases high, then one flip of to_pls moves A and B together.
    cmd(aic_pkg::CMD_WR_ENV2, 32'h0000_8000);
    run(2);
    to_pls = 1'b0;
    wait_n(30);
    cmd(aic_pkg::CMD_WR_ENV2, 32'h0000_4000);
    to_pls = 1'b1;
    wait_n(30);
    chk("enc_err", 32'd1, 32'(n_ee));
    chk("pls_err", 32'd1, 32'(n_pe));
    run(2);
    to_pls = 1'b0;
  endtask : t_pulser
  task automatic t_stop();
    do_reset();
    pulse(axis_stopped);
    chk("stop flag", 32'h0, 32'(stop_interrupt_flag));
    cmd(aic_pkg::CMD_WR_ENV2, 32'h4000_0000);
    pulse(axis_stopped);
    chk("int_n", 32'h0, 32'(int_n));
    pulse(status_read);
    chk("stop flag", 32'h0, 32'(stop_interrupt_flag));
    cmd(aic_pkg::CMD_WR_ENV2, 32'hc000_0000);
    pulse(axis_stopped);
    pulse(status_read);
    chk("stop flag", 32'h1, 32'(stop_interrupt_flag));
    cmd(aic_pkg::CMD_CLR_STOP, 32'h0);
    wait_n(2);
    chk("int_n", 32'h1, 32'(int_n));
    cmd(aic_pkg::CMD_WR_ENV2, 32'h4000_0000);
    serial_mode = 1'b1;
    pulse(axis_stopped);
    pulse(status_read);
    chk("stop flag", 32'h1, 32'(stop_interrupt_flag));
    serial_mode = 1'b0;
  endtask : t_stop
  task automatic t_latch();
    do_reset();
    cmd(aic_pkg::CMD_WR_ENV3, 32'h2);
    repeat (5) pulse(cmd_pulse);
    chk("counter_two", 32'd5, 32'(counter_two));
    pulse(latch_trigger);
    chk("latch one", 32'd5, 32'(latch_register_one));
    cmd(aic_pkg::CMD_WR_ENV3, 32'h12);
    cmd_dir = 1'b1;
    repeat (2) pulse(cmd_pulse);
    pulse(latch_trigger);
    chk("latch one", 32'd3, 32'(latch_register_one));
    chk("counter_one", 32'd0, 32'(counter_one));
    cmd(aic_pkg::CMD_WR_ENV3, 32'h132);
    cmd_dir = 1'b0;
    repeat (2) pulse(cmd_pulse);
    pulse(latch_trigger);
    chk("latch one", 32'd3, 32'(latch_register_one));
    chk("counter_two", 32'd0, 32'(counter_two));
    chk("latch two", 32'd5, 32'(latch_register_two));
    cmd(aic_pkg::CMD_LATCH, 32'h0);
    wait_n(2);
    chk("latch one", 32'd2, 32'(latch_register_one));
    cmd(aic_pkg::CMD_WR_ENV3, 32'h82);
    repeat (4) pulse(cmd_pulse);
    chk("counter_one", 32'd0, 32'(counter_one));
  endtask : t_latch
  task automatic origin_run(input logic hs);
    // Drop both levels for two edges so the sequencer idles and sees a fresh edge.
    {origin_on, origin_return_active} = '0;
    wait_n(2);
    high_speed_start = hs;
    origin_return_active = 1'b1;
    wait_n(3);
    origin_on = 1'b1;
    wait_n(3);
  endtask : origin_run
  task automatic t_origin();
    do_reset();
    repeat (3) pulse(cmd_pulse);
    origin_run(1'b0);
    chk("stop_req", 32'd1, 32'(n_stop));
    chk("counter_one", 32'd0, 32'(counter_one));
    origin_run(1'b1);
    chk("decel_req", 32'd1, 32'(n_dec));
    cmd(aic_pkg::CMD_WR_ENV2, 32'h3100_0000);
    cmd(aic_pkg::CMD_WR_ENV3, 32'h40);
    repeat (2) pulse(cmd_pulse);
    origin_run(1'b1);
    chk("decel_req", 32'd2, 32'(n_dec));
    encoder_zphase_input = 1'b1;
    wait_n(40);
    encoder_zphase_input = 1'b0;
    wait_n(40);
    chk("stop_req", 32'd1, 32'(n_stop));
    encoder_zphase_input = 1'b1;
    wait_n(40);
    chk("stop_req", 32'd2, 32'(n_stop));
    chk("counter_one", 32'd0, 32'(counter_one));
    chk("latch one", 32'd2, 32'(latch_register_one));
  endtask : t_origin
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    t_regs();
    t_encoder();
    t_pulser();
    t_stop();
    t_latch();
    t_origin();
    tally_and_finish();
  end
  // The tests need about 20 us; ten times that means a hang.
  initial
  begin
    #200000;
    err_total++;
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
